// ### common/cvc_pkg.sv
// Shared constants and types for the converter control pin logic.
package cvc_pkg;

    // Core clock and fault pulse timing.
    localparam int CLK_PERIOD_NS      = 50;
    localparam int FAULT_PULSE_NS     = 1000;
    localparam int FAULT_PULSE_CYCLES =
        (FAULT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Cycles the host reset detector stays blind after our own pulse.
    localparam int PULSE_GUARD_CYCLES = 3;
    localparam int PULSE_CNT_W        = 8;

    // Boost / pass-through thresholds in millivolts.
    localparam int          THR_W       = 12;
    localparam logic [11:0] THR_LOW_MV  = 12'h0C4E;
    localparam logic [11:0] THR_HIGH_MV = 12'h0D16;

    // Serial control port.
    localparam logic [6:0] I2C_DEV_ADDR = 7'h75;
    localparam int         BYTE_W       = 8;
    localparam int         ROLE_BIT     = 0;

    // Multi-function pin role: 1 = reset in / fault out, 0 = mode input.
    localparam logic ROLE_RESET_FAULT = 1'b1;
    localparam logic ROLE_MODE_INPUT  = 1'b0;

    // Synchroniser lanes.
    localparam int SYNC_W     = 12;
    localparam int SY_EN      = 0;
    localparam int SY_PT_N    = 1;
    localparam int SY_VSEL    = 2;
    localparam int SY_GPIO    = 3;
    localparam int SY_THERMAL = 4;
    localparam int SY_VOUT    = 5;
    localparam int SY_ILIM    = 6;
    localparam int SY_DISCH   = 7;
    localparam int SY_START   = 8;
    localparam int SY_SCL     = 9;
    localparam int SY_SDA     = 10;
    localparam int SY_WR      = 11;

    typedef enum logic [1:0] {
        ST_OFF       = 2'b00,
        ST_STARTUP   = 2'b01,
        ST_RUN       = 2'b11,
        ST_DISCHARGE = 2'b10
    } cvc_seq_t;

    typedef enum logic [1:0] {
        PH_ADDR  = 2'b00,
        PH_WDATA = 2'b01,
        PH_RDATA = 2'b11,
        PH_IDLE  = 2'b10
    } cvc_phase_t;

endpackage

// ### common/cvc_link_if.sv
// Signals between the core clock domain and the serial clock domain.
`timescale 1ns/100ps
interface cvc_link_if;
    logic       frame_clr;
    logic       wr_done;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    modport ctrl (
        output frame_clr,
        output rd_data,
        input  wr_done,
        input  wr_data
    );

    modport port (
        input  frame_clr,
        input  rd_data,
        output wr_done,
        output wr_data
    );
endinterface

// ### logic/cvc_fault_pulse.sv
// Fault pulse timer driving the open-drain enable of the shared pin.
`timescale 1ns/100ps
module cvc_fault_pulse #(
    parameter int PULSE_CYCLES = cvc_pkg::FAULT_PULSE_CYCLES,
    parameter int GUARD_CYCLES = cvc_pkg::PULSE_GUARD_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic trigger,
    output logic      pulse_oe,
    output logic      busy
);
    import cvc_pkg::*;

    localparam logic [PULSE_CNT_W-1:0] TOTAL =
        PULSE_CNT_W'(PULSE_CYCLES + GUARD_CYCLES);
    localparam logic [PULSE_CNT_W-1:0] GUARD = PULSE_CNT_W'(GUARD_CYCLES);

    typedef struct packed {
        logic [PULSE_CNT_W-1:0] cnt;
        logic                   oe;
        logic                   busy;
    } cvc_pulse_state_t;

    cvc_pulse_state_t state_reg;
    cvc_pulse_state_t state_next;

    // A trigger during a pulse or its guard time is dropped on purpose.
    always_comb
    begin
        state_next = state_reg;
        if (state_reg.cnt != '0)
            state_next.cnt = state_reg.cnt - 1'b1;
        else if (trigger)
            state_next.cnt = TOTAL;
        state_next.oe   = (state_next.cnt > GUARD);
        state_next.busy = (state_next.cnt != '0);
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign pulse_oe = state_reg.oe;
    assign busy     = state_reg.busy;
endmodule

// ### logic/cvc_i2c_port.sv
// Serial control port slave running on the host serial clock.
`timescale 1ns/100ps
module cvc_i2c_port (
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_oe,
    cvc_link_if.port  link
);
    import cvc_pkg::*;

    typedef struct packed {
        cvc_phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic       rw;
        logic       match;
        logic       wr_done;
    } cvc_i2c_state_t;

    cvc_i2c_state_t state_reg;
    cvc_i2c_state_t state_next;
    logic           oe_next;

    // Sample on the rising serial clock; a cleared frame waits for address.
    always_comb
    begin
        state_next = state_reg;
        if (state_reg.bit_cnt == 4'd8)
        begin
            state_next.bit_cnt = 4'd0;
            case (state_reg.phase)
                PH_ADDR:
                    state_next.phase = state_reg.match ?
                        (state_reg.rw ? PH_RDATA : PH_WDATA) : PH_IDLE;
                PH_WDATA:
                begin
                    state_next.wr_done = 1'b1;
                    state_next.phase   = PH_IDLE;
                end
                default:
                    state_next.phase = PH_IDLE;
            endcase
        end
        else if (state_reg.phase != PH_IDLE)
        begin
            state_next.shift   = {state_reg.shift[6:0], sda_in};
            state_next.bit_cnt = state_reg.bit_cnt + 4'd1;
            if (state_reg.bit_cnt == 4'd7 && state_reg.phase == PH_ADDR)
            begin
                state_next.match = (state_reg.shift[6:0] == I2C_DEV_ADDR);
                state_next.rw    = sda_in;
            end
        end
    end

    // Drive changes only while the serial clock is low.
    always_comb
    begin
        oe_next = 1'b0;
        if (state_reg.bit_cnt == 4'd8)
            oe_next = (state_reg.phase == PH_ADDR && state_reg.match)
                      || state_reg.phase == PH_WDATA;
        else if (state_reg.phase == PH_RDATA)
            oe_next = !link.rd_data[3'd7 - state_reg.bit_cnt[2:0]];
    end

    // Held clear by the core while disabled and pulsed at every start.
    always_ff @(posedge scl or posedge link.frame_clr)
    begin
        if (link.frame_clr)
            state_reg <= '{PH_ADDR, 4'd0, 8'h00, 1'b0, 1'b0, 1'b0};
        else
            state_reg <= state_next;
    end

    always_ff @(negedge scl or posedge link.frame_clr)
    begin
        if (link.frame_clr)
            sda_oe <= 1'b0;
        else
            sda_oe <= oe_next;
    end

    assign link.wr_done = state_reg.wr_done;
    assign link.wr_data = state_reg.shift;
endmodule

// ### logic/cvc_top.sv
// Control pin logic of the battery boost / pass-through converter.
//
// Contract
// - A rising edge of enable returns every internal register to default.
// - With enable low the part is shut down and the serial port is deaf.
// - In shutdown the bypass input picks forced bypass or minimum regulation.
// - With enable high and the bypass input high the part runs with automatic boost/bypass change.
// - The shared pin is a mode input or reset-in/fault-out, the latter default.
// - A host falling edge in reset role starts discharge then a new start-up.
// - A fault pulls the shared pin low for one pulse, then releases it.
// - Thermal shutdown, output out of limits and current limit raise a fault.
// - Mode input low gives PWM at high load and PFM at light load.
// - Mode input high gives low-noise mode with PWM forced.
// - A low level on the bypass input forces pass-through.
// - The threshold select level chooses the boost/bypass threshold.
// - The host clocks the serial port; data moves both ways on the data line.
// - The threshold is 3.15 V for select low and 3.35 V for select high.
`timescale 1ns/100ps
module cvc_top #(
    parameter int FAULT_PULSE_LEN = cvc_pkg::FAULT_PULSE_CYCLES
) (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       enable,
    input  wire logic                       passthrough_force_n,
    input  wire logic                       thr_select,
    input  wire logic                       gpio_in,
    input  wire logic                       thermal_shutdown,
    input  wire logic                       vout_out_of_limits,
    input  wire logic                       current_limit,
    input  wire logic                       discharge_done,
    input  wire logic                       startup_done,
    input  wire logic                       scl,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe,
    output logic                            gpio_out,
    output logic                            gpio_oe,
    output logic                            shutdown,
    output logic                            pass_force,
    output logic                            min_regulate,
    output logic                            auto_transition,
    output logic [cvc_pkg::THR_W-1:0]       threshold_mv,
    output logic                            pwm_forced,
    output logic                            low_noise,
    output logic                            discharge_en,
    output logic                            startup_run,
    output logic                            role_reset_fault
);
    import cvc_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic [SYNC_W-1:0] prev;
        cvc_seq_t          seq;
        logic              role;
        logic              frame_clr;
        logic              shutdown;
        logic              pass_force;
        logic              min_regulate;
        logic              auto_transition;
        logic [THR_W-1:0]  threshold_mv;
        logic              pwm_forced;
        logic              low_noise;
        logic              discharge_en;
        logic              startup_run;
    } cvc_top_state_t;

    cvc_top_state_t    state_reg;
    cvc_top_state_t    state_next;
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] s;
    logic [SYNC_W-1:0] p;
    logic              en_rise;
    logic              start_seen;
    logic              wr_rise;
    logic              fault_rise;
    logic              fault_trig;
    logic              host_reset;
    logic              pulse_busy;
    logic              pulse_oe;

    cvc_link_if link ();

    cvc_i2c_port u_port (
        .scl    (scl),
        .sda_in (sda_in),
        .sda_oe (sda_oe),
        .link   (link)
    );

    cvc_fault_pulse #(
        .PULSE_CYCLES (FAULT_PULSE_LEN),
        .GUARD_CYCLES (PULSE_GUARD_CYCLES)
    ) u_pulse (
        .clk      (clk),
        .reset_n  (reset_n),
        .trigger  (fault_trig),
        .pulse_oe (pulse_oe),
        .busy     (pulse_busy)
    );

    // Every pin and the serial-domain write flag pass two flip-flops.
    assign raw_in = {link.wr_done, sda_in, scl, startup_done,
                     discharge_done, current_limit, vout_out_of_limits,
                     thermal_shutdown, gpio_in, thr_select,
                     passthrough_force_n, enable};
    assign s = state_reg.sync2;
    assign p = state_reg.prev;

    assign en_rise    = s[SY_EN] && !p[SY_EN];
    // A start is the data line falling while the serial clock stays high.
    assign start_seen = s[SY_SCL] && p[SY_SCL] && p[SY_SDA] && !s[SY_SDA];
    assign wr_rise    = s[SY_WR] && !p[SY_WR];
    assign fault_rise = (s[SY_THERMAL] && !p[SY_THERMAL])
                        || (s[SY_VOUT] && !p[SY_VOUT])
                        || (s[SY_ILIM] && !p[SY_ILIM]);
    assign fault_trig = fault_rise && s[SY_EN] && state_reg.seq != ST_OFF
                        && state_reg.role == ROLE_RESET_FAULT;
    // Our own pulse echoes back through the synchroniser; busy masks it.
    assign host_reset = p[SY_GPIO] && !s[SY_GPIO] && !pulse_busy
                        && state_reg.role == ROLE_RESET_FAULT
                        && state_reg.seq == ST_RUN;

    // Besides the enable-rise default, the role only changes on a finished write, before any later read.
    assign link.frame_clr = state_reg.frame_clr;
    assign link.rd_data   = {7'h00, state_reg.role};

    always_comb
    begin
        state_next       = state_reg;
        state_next.sync1 = raw_in;
        state_next.sync2 = state_reg.sync1;
        state_next.prev  = state_reg.sync2;

        state_next.frame_clr = !s[SY_EN] || start_seen;

        if (en_rise)
            state_next.role = ROLE_RESET_FAULT;
        else if (wr_rise && s[SY_EN])
            state_next.role = link.wr_data[ROLE_BIT];

        if (!s[SY_EN])
            state_next.seq = ST_OFF;
        else
        begin
            case (state_reg.seq)
                ST_OFF:
                    state_next.seq = ST_STARTUP;
                ST_STARTUP:
                    if (s[SY_START])
                        state_next.seq = ST_RUN;
                ST_RUN:
                    if (host_reset)
                        state_next.seq = ST_DISCHARGE;
                ST_DISCHARGE:
                    if (s[SY_DISCH])
                        state_next.seq = ST_STARTUP;
                default:
                    state_next.seq = ST_OFF;
            endcase
        end

        state_next.shutdown     = !s[SY_EN];
        state_next.pass_force   = !s[SY_PT_N];
        state_next.min_regulate = !s[SY_EN] && s[SY_PT_N];
        state_next.auto_transition = s[SY_EN] && s[SY_PT_N];
        state_next.threshold_mv = s[SY_VSEL] ?
                                  THR_HIGH_MV : THR_LOW_MV;

        // In the reset role the pin carries no mode, so load decides.
        if (s[SY_EN] && state_reg.role == ROLE_MODE_INPUT && s[SY_GPIO])
        begin
            state_next.pwm_forced = 1'b1;
            state_next.low_noise  = 1'b1;
        end
        else
        begin
            state_next.pwm_forced = 1'b0;
            state_next.low_noise  = 1'b0;
        end

        state_next.discharge_en = (state_next.seq == ST_DISCHARGE);
        state_next.startup_run  = (state_next.seq == ST_STARTUP);
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            state_reg <= '{'0, '0, '0, ST_OFF, ROLE_RESET_FAULT, 1'b1,
                           1'b1, 1'b0, 1'b0, 1'b0, THR_LOW_MV,
                           1'b0, 1'b0, 1'b0, 1'b0};
        else
            state_reg <= state_next;
    end

    assign sda_out          = 1'b0;
    assign gpio_out         = 1'b0;
    assign gpio_oe          = pulse_oe;
    assign shutdown         = state_reg.shutdown;
    assign pass_force       = state_reg.pass_force;
    assign min_regulate     = state_reg.min_regulate;
    assign auto_transition  = state_reg.auto_transition;
    assign threshold_mv     = state_reg.threshold_mv;
    assign pwm_forced       = state_reg.pwm_forced;
    assign low_noise        = state_reg.low_noise;
    assign discharge_en     = state_reg.discharge_en;
    assign startup_run      = state_reg.startup_run;
    assign role_reset_fault = state_reg.role;

    // Helper: length of the current low pulse on the shared pin.
    localparam int PULSE_LEN_CHECK = FAULT_PULSE_LEN;
    logic [PULSE_CNT_W-1:0] low_cnt_reg;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            low_cnt_reg <= '0;
        else if (gpio_oe)
            low_cnt_reg <= low_cnt_reg + 1'b1;
        else
            low_cnt_reg <= '0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_host_fall;
        host_reset && s[SY_EN];
    endsequence

    sequence s_discharge_phase;
        discharge_en && state_reg.seq == ST_DISCHARGE;
    endsequence

    sequence s_discharge_end;
        state_reg.seq == ST_DISCHARGE && s[SY_DISCH] && s[SY_EN];
    endsequence

    sequence s_restart;
        startup_run && state_reg.seq == ST_STARTUP;
    endsequence

    a_enable_rise_default: assert property (
        en_rise |=> role_reset_fault == ROLE_RESET_FAULT
                    && state_reg.seq == ST_STARTUP && startup_run)
        else $error("enable rise did not restore defaults");

    a_shutdown_deaf_port: assert property (
        !s[SY_EN] |=> shutdown && link.frame_clr
                      && state_reg.seq == ST_OFF)
        else $error("shutdown or port disable missing while off");

    a_shutdown_bypass_pick: assert property (
        !s[SY_EN] |=> min_regulate == $past(s[SY_PT_N])
                      && pass_force == !$past(s[SY_PT_N]))
        else $error("shutdown bypass choice wrong");

    a_enabled_auto_mode: assert property (
        s[SY_EN] && s[SY_PT_N] |=> auto_transition && !shutdown
                                   && !min_regulate)
        else $error("enabled part not in automatic mode");

    a_host_reset_start: assert property (
        s_host_fall |=> s_discharge_phase)
        else $error("host reset did not start discharge");

    a_reset_restart: assert property (
        s_discharge_end |=> s_restart)
        else $error("discharge did not hand over to start-up");

    a_fault_raises_pulse: assert property (
        fault_trig && !pulse_busy |=> gpio_oe [*2])
        else $error("fault event did not pull the pin low");

    a_fault_pulse_length: assert property (
        $fell(gpio_oe) |-> low_cnt_reg == PULSE_LEN_CHECK)
        else $error("fault pulse length wrong");

    a_mode_low_auto: assert property (
        s[SY_EN] && state_reg.role == ROLE_MODE_INPUT && !s[SY_GPIO]
        |=> !pwm_forced && !low_noise)
        else $error("mode low did not allow light-load PFM");

    a_mode_high_pwm: assert property (
        s[SY_EN] && state_reg.role == ROLE_MODE_INPUT && s[SY_GPIO]
        |=> pwm_forced && low_noise)
        else $error("mode high did not force PWM");

    a_bypass_force_low: assert property (
        !s[SY_PT_N] |=> pass_force && !auto_transition)
        else $error("bypass input low did not force pass-through");

    a_threshold_pick: assert property (
        s[SY_EN] |=> threshold_mv ==
            ($past(s[SY_VSEL]) ? THR_HIGH_MV : THR_LOW_MV))
        else $error("threshold does not follow select");

    a_port_write_role: assert property (
        wr_rise && s[SY_EN] && !en_rise
        |=> role_reset_fault == $past(link.wr_data[ROLE_BIT]))
        else $error("serial write did not set the pin role");

endmodule

// ### verification/cvc_host_model.sv
// Host model: serial master on its own clock plus the shared pin driver.
`timescale 1ns/100ps
module cvc_host_model (
    output logic      scl,
    output logic      sda,
    output logic      gpio,
    input  wire logic sda_oe,
    input  wire logic gpio_oe,
    input  wire logic gpio_pull_low
);
    import cvc_pkg::*;
    // Each serial phase lasts many core cycles, since the port detects
    // start in the core domain.
    localparam int HALF = 20;
    logic lclk;
    logic sda_low;
    initial
    begin
        lclk = 1'b0;
        #3;
        forever #7.5 lclk = ~lclk;
    end
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Both lines are open drain with pull-ups.
    assign sda  = (sda_low || sda_oe) ? 1'b0 : 1'b1;
    assign gpio = (gpio_pull_low || gpio_oe) ? 1'b0 : 1'b1;
    task automatic tick(input int n);
        repeat (n) @(posedge lclk);
    endtask
    // Data changes only mid-way through the low phase of the clock.
    task automatic bit_cyc(input logic b, output logic seen);
        tick(HALF / 2);
        sda_low = ~b;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF);
        seen = sda;
        scl = 1'b0;
    endtask
    // One whole frame: start, address, one byte, released ack, stop.
    task automatic frame(input logic [7:0] a, input logic [7:0] d,
                         output logic ack_a, output logic ack_d,
                         output logic [7:0] r);
        logic s;
        sda_low = 1'b0;
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b1;
        tick(HALF);
        scl = 1'b0;
        for (int i = 7; i >= 0; i--) bit_cyc(a[i], s);
        bit_cyc(1'b1, ack_a);
        for (int i = 7; i >= 0; i--) bit_cyc(d[i], r[i]);
        bit_cyc(1'b1, ack_d);
        tick(HALF / 2);
        sda_low = 1'b1;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b0;
        tick(HALF);
    endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the converter control pin logic.
`timescale 1ns/100ps
module tb_top;
    import cvc_pkg::*;
    localparam int  PLEN = 4;
    localparam logic [7:0] WR_A = {I2C_DEV_ADDR, 1'b0};
    localparam logic [7:0] RD_A = {I2C_DEV_ADDR, 1'b1};
    logic clk, reset_n, enable, pt_n, thr_sel, therm, vout_bad, ilim;
    logic dis_done, st_done, host_low, scl, sda, gpio, sda_out, sda_oe;
    logic gpio_out, gpio_oe, shutdown, pass_force, min_reg, auto_tr;
    logic pwm_f, low_noise, dis_en, st_run, role, a0, a1;
    logic [7:0]       rd;
    logic [THR_W-1:0] thr_mv;
    int               err_count;
    int               checked;
    cvc_top #(.FAULT_PULSE_LEN(PLEN)) dut (
        .clk(clk), .reset_n(reset_n), .enable(enable),
        .passthrough_force_n(pt_n), .thr_select(thr_sel), .gpio_in(gpio),
        .thermal_shutdown(therm), .vout_out_of_limits(vout_bad),
        .current_limit(ilim), .discharge_done(dis_done),
        .startup_done(st_done), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .shutdown(shutdown), .pass_force(pass_force),
        .min_regulate(min_reg), .auto_transition(auto_tr),
        .threshold_mv(thr_mv), .pwm_forced(pwm_f), .low_noise(low_noise),
        .discharge_en(dis_en), .startup_run(st_run),
        .role_reset_fault(role));
    cvc_host_model host (
        .scl(scl), .sda(sda), .gpio(gpio), .sda_oe(sda_oe),
        .gpio_oe(gpio_oe), .gpio_pull_low(host_low));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp,
                       input string msg);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic wrap_up();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Waits a bounded time for the pulse, then counts how long it stands.
    task automatic pulse_len(output int n);
        n = 0;
        while (gpio_oe !== 1'b1 && n < 10)
        begin
            n++;
            cyc(1);
        end
        if (n == 10)
        begin
            chk(12'h0001, 12'h0000, "no fault pulse");
            wrap_up();
        end
        n = 0;
        while (gpio_oe === 1'b1 && n < 40)
        begin
            n++;
            cyc(1);
        end
    endtask
    task automatic t_shutdown();
        @(posedge clk) pt_n <= 1'b0;
        cyc(4);
        chk(shutdown, 1, "not shut down");
        chk(pass_force, 1, "pass force off");
        chk(min_reg, 0, "min regulate on");
        @(posedge clk) pt_n <= 1'b1;
        cyc(4);
        chk({pass_force, min_reg}, 12'h0001, "min regulate off");
        host.frame(WR_A, 8'h00, a0, a1, rd);
        chk(a0, 1, "ack while disabled");
    endtask
    task automatic t_enable();
        @(posedge clk) enable <= 1'b1;
        cyc(4);
        chk({shutdown, auto_tr, st_run}, 12'h0003, "not running");
        chk(role, ROLE_RESET_FAULT, "role default");
        for (int s = 0; s < 2; s++)
        begin
            @(posedge clk) thr_sel <= s[0];
            cyc(4);
            chk(thr_mv, s ? 12'h0D16 : 12'h0C4E, "threshold");
        end
        @(posedge clk) st_done <= 1'b1;
        cyc(4);
        chk(st_run, 0, "start-up stuck");
    endtask
    task automatic t_fault();
        int n;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk) {ilim, vout_bad, therm} <= 3'b001 << k;
            pulse_len(n);
            chk(12'(n), 12'(PLEN), "pulse length");
            chk(gpio, 1, "pin not released");
            chk({sda_out, gpio_out}, 12'h0000, "drive level");
            @(posedge clk) {ilim, vout_bad, therm} <= 3'b000;
            cyc(8);
        end
    endtask
    task automatic t_manual();
        @(posedge clk)
        begin
            host_low <= 1'b1;
            st_done <= 1'b0;
        end
        cyc(4);
        chk({dis_en, st_run}, 12'h0002, "no discharge");
        @(posedge clk)
        begin
            host_low <= 1'b0;
            dis_done <= 1'b1;
        end
        cyc(4);
        chk({dis_en, st_run}, 12'h0001, "no new start-up");
        @(posedge clk)
        begin
            dis_done <= 1'b0;
            st_done <= 1'b1;
        end
        cyc(4);
    endtask
    task automatic t_mode();
        host.frame(WR_A, 8'h00, a0, a1, rd);
        chk({a0, a1}, 12'h0000, "write not acked");
        cyc(4);
        chk(role, ROLE_MODE_INPUT, "role not mode");
        host.frame(RD_A, 8'hFF, a0, a1, rd);
        chk(a0, 0, "read not acked");
        chk(rd, 12'h0000, "read byte");
        chk({pwm_f, low_noise}, 12'h0003, "low noise off");
        @(posedge clk) host_low <= 1'b1;
        cyc(4);
        chk({pwm_f, low_noise}, 12'h0000, "pwm forced");
        @(posedge clk) therm <= 1'b1;
        cyc(10);
        chk(gpio_oe, 0, "pulse in mode role");
        @(posedge clk)
        begin
            therm <= 1'b0;
            host_low <= 1'b0;
        end
        cyc(4);
    endtask
    task automatic t_en_reset();
        // Start-up done must drop, or start-up ends before it is seen.
        @(posedge clk)
        begin
            enable <= 1'b0;
            st_done <= 1'b0;
        end
        cyc(4);
        @(posedge clk) enable <= 1'b1;
        cyc(4);
        chk({role, st_run}, 12'h0003, "enable rise reset");
        host.frame(RD_A, 8'hFF, a0, a1, rd);
        chk(a0, 0, "read after reset not acked");
        chk(rd, 12'h0001, "read byte after reset");
    endtask
    initial
    begin
        {reset_n, enable, thr_sel, therm, vout_bad, ilim} = 6'h00;
        {dis_done, st_done, host_low} = 3'h0;
        pt_n = 1'b1;
        err_count = 0;
        checked = 0;
        cyc(4);
        @(posedge clk) reset_n <= 1'b1;
        cyc(3);
        t_shutdown();
        t_enable();
        t_fault();
        t_manual();
        t_mode();
        t_en_reset();
        wrap_up();
    end
endmodule
